// ---- verilog/prlc_defines.svh ----
// constants for the power, reset, lock and emulation control block
`ifndef PRLC_DEFINES_SVH
`define PRLC_DEFINES_SVH
`define PRLC_PD_BIT        1
`define PRLC_POF_BIT       4
`define PRLC_POWER_CONTROL_REG_POR      8'h10
`define PRLC_POWER_CONTROL_REG_WARM_KEEP 8'h10
`define PRLC_KEY_DEPTH     64
`define PRLC_KEY_ERASED    8'hFF
`define PRLC_LOCK_NONE     3'h0
`define PRLC_LOCK_ONE      3'h1
`define PRLC_LOCK_TWO      3'h3
`define PRLC_LOCK_THREE    3'h7
`define PRLC_SYNC_W        6
// synchroniser reset: pins idle high, reset level idles low
`define PRLC_SYNC_IDLE     6'h1F
`endif

// ---- verilog/prlc_pkg.sv ----
// types for the power, reset, lock and emulation control block
package prlc_pkg;
  typedef logic [7:0] prlc_byte_t;
  typedef enum logic [2:0] {
    LVL_NONE, LVL_ONE, LVL_TWO, LVL_THREE, LVL_UNDEF
  } prlc_level_e;
  typedef enum logic [1:0] {
    ST_RUN, ST_DOWN, ST_WAKE, ST_HANDLER
  } prlc_pd_state_e;
  typedef struct packed {
    logic block_ext_code_read;
    logic ea_latched_mode;
    logic program_disable;
    logic verify_disable;
    logic ext_exec_disable;
  } prlc_protect_s;
  typedef struct packed {
    logic active;
    logic port0_float;
    logic weak_pullup;
  } prlc_emul_s;
endpackage : prlc_pkg

// ---- verilog/prlc_key_array.sv ----
// encryption key byte store with whole-array erase
`include "prlc_defines.svh"
module prlc_key_array #(
  parameter int DEPTH = `PRLC_KEY_DEPTH,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             i_clock,
  input  wire logic             i_por_n,
  input  wire logic             i_write,
  input  wire logic [AW-1:0]    i_waddr,
  input  wire prlc_pkg::prlc_byte_t i_wdata,
  input  wire logic             i_erase,
  input  wire logic [AW-1:0]    i_raddr,
  output prlc_pkg::prlc_byte_t  o_rdata
);
  import prlc_pkg::*;
  prlc_byte_t mem_r [DEPTH];

  // unprogrammed and erased bytes read all ones
  always_ff @(posedge i_clock or negedge i_por_n) begin
    if (!i_por_n) begin
      for (int k = 0; k < DEPTH; k++) begin
        mem_r[k] <= `PRLC_KEY_ERASED;
      end
    end else if (i_erase) begin
      for (int k = 0; k < DEPTH; k++) begin
        mem_r[k] <= `PRLC_KEY_ERASED;
      end
    end else if (i_write) begin
      mem_r[i_waddr] <= i_wdata;
    end
  end

  assign o_rdata = mem_r[i_raddr];
endmodule : prlc_key_array

// ---- verilog/prlc_top.sv ----
// power-down exit, cold start flag, program lock and emulation entry
//
// Contract
// - power-down left only by reset or interrupt
// - reset reinitialises registers, keeps data RAM
// - interrupt wake keeps all, clears power-down bit
// - wake needs level interrupt; low restarts, high exits
// - after handler return resume past power-down
// - cold start flag bit 4 set at power-up
// - software may set and clear cold flag
// - warm reset leaves cold start flag unchanged
// - verify output is code XNOR sequenced key
// - unprogrammed key bytes read all ones
// - no lock bits: no protection, still encrypted
// - first lock: block reads, latch pin, no programming
// - two locks: also code verify disabled
// - three locks: also external execution disabled
// - other lock combinations are undefined
// - erase clears key array and lock bits
// - emulation entered by strobe low during reset
// - emulation: port 0 floats, others pulled weakly
// - emulation left only by a valid reset
`include "prlc_defines.svh"
module prlc_top #(
  parameter int KEY_DEPTH = `PRLC_KEY_DEPTH,
  parameter int KAW       = $clog2(KEY_DEPTH)
) (
  input  wire logic                  i_clock,
  input  wire logic                  i_reset_n,
  input  wire logic                  i_por_n,
  input  wire logic                  i_power_control_reg_wr,
  input  wire prlc_pkg::prlc_byte_t  i_power_control_reg_wdata,
  input  wire logic                  i_ext_irq_zero,
  input  wire logic                  i_ext_irq_one,
  input  wire logic [1:0]            i_irq_enable,
  input  wire logic [1:0]            i_irq_level_mode,
  input  wire logic [15:0]           i_next_pc,
  input  wire logic                  i_return_from_interrupt,
  input  wire logic                  i_external_access_pin,
  input  wire logic                  i_ale,
  input  wire logic                  i_program_store_enable,
  input  wire logic [2:0]            i_lock_program,
  input  wire logic                  i_key_write,
  input  wire logic [KAW-1:0]        i_key_addr,
  input  wire prlc_pkg::prlc_byte_t  i_key_data,
  input  wire logic                  i_erase,
  input  wire logic                  i_verify_req,
  input  wire logic [15:0]           i_verify_addr,
  input  wire prlc_pkg::prlc_byte_t  i_code_byte,
  output prlc_pkg::prlc_byte_t       o_power_control_reg,
  output logic                       o_osc_enable,
  output logic                       o_powerdown_active,
  output logic [1:0]                 o_wake_irq,
  output logic                       o_resume_valid,
  output logic [15:0]                o_resume_addr,
  output logic                       o_sfr_reinit,
  output prlc_pkg::prlc_protect_s    o_protect,
  output prlc_pkg::prlc_level_e      o_level,
  output logic                       o_external_access,
  output logic [2:0]                 o_lock_bits,
  output prlc_pkg::prlc_byte_t       o_verify_data,
  output logic                       o_verify_valid,
  output logic                       o_verify_refused,
  output prlc_pkg::prlc_emul_s       o_emul
);
  import prlc_pkg::*;

  // pin synchronisers: reset level, program_store_enable, ale, ea, irq1, irq0
  logic [`PRLC_SYNC_W-1:0] sync_in;
  logic [`PRLC_SYNC_W-1:0] sync_meta_r;
  logic [`PRLC_SYNC_W-1:0] sync_q_r;
  assign sync_in = {~i_reset_n, i_program_store_enable, i_ale,
                    i_external_access_pin, i_ext_irq_one, i_ext_irq_zero};

  localparam logic [`PRLC_SYNC_W-1:0] SYNC_IDLE = `PRLC_SYNC_IDLE;

  genvar g;
  generate
    for (g = 0; g < `PRLC_SYNC_W; g++) begin : g_sync
      always_ff @(posedge i_clock or negedge i_por_n) begin
        if (!i_por_n) begin
          sync_meta_r[g] <= SYNC_IDLE[g];
          sync_q_r[g]    <= SYNC_IDLE[g];
        end else begin
          sync_meta_r[g] <= sync_in[g];
          sync_q_r[g]    <= sync_meta_r[g];
        end
      end
    end
  endgenerate

  logic       rst_q;
  logic       program_store_enable_q;
  logic       ale_q;
  logic       ea_q;
  logic [1:0] irq_q;
  logic       rst_d_r;
  assign rst_q  = sync_q_r[5];
  assign program_store_enable_q = sync_q_r[4];
  assign ale_q  = sync_q_r[3];
  assign ea_q   = sync_q_r[2];
  assign irq_q  = sync_q_r[1:0];

  // power control register, power-on loads 8'h10, warm reset keeps only bit 4
  prlc_byte_t power_control_reg_r;
  prlc_byte_t power_control_reg_nxt;
  logic       pd_clear;

  always_comb begin
    power_control_reg_nxt = power_control_reg_r;
    if (rst_q) begin
      power_control_reg_nxt = power_control_reg_r & `PRLC_POWER_CONTROL_REG_WARM_KEEP;
    end else if (i_power_control_reg_wr) begin
      power_control_reg_nxt = i_power_control_reg_wdata;
    end
    if (pd_clear) begin
      power_control_reg_nxt[`PRLC_PD_BIT] = 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_por_n) begin
    if (!i_por_n) begin
      power_control_reg_r <= `PRLC_POWER_CONTROL_REG_POR;
    end else begin
      power_control_reg_r <= power_control_reg_nxt;
    end
  end

  // power-down sequencer
  prlc_pd_state_e state_r;
  prlc_pd_state_e state_nxt;
  logic [1:0]     wake_src_r;
  logic [1:0]     wake_src_nxt;
  logic [15:0]    resume_r;
  logic [15:0]    resume_nxt;
  logic [1:0]     wake_pulse;
  logic           resume_pulse;
  logic [1:0]     wake_low;

  assign wake_low = i_irq_enable & i_irq_level_mode & ~irq_q;

  always_comb begin
    state_nxt    = state_r;
    wake_src_nxt = wake_src_r;
    resume_nxt   = resume_r;
    wake_pulse   = 2'h0;
    resume_pulse = 1'b0;
    pd_clear     = 1'b0;
    case (state_r)
      ST_RUN: begin
        // short reset: enter power-down on a set power-down bit only after reset and reinit have dropped
        if (power_control_reg_r[`PRLC_PD_BIT] && !rst_q && !rst_d_r &&
            !o_sfr_reinit) begin
          state_nxt  = ST_DOWN;
          resume_nxt = i_next_pc;
        end
      end
      ST_DOWN: begin
        if (wake_low != 2'h0) begin
          state_nxt    = ST_WAKE;
          wake_src_nxt = wake_low[0] ? 2'h1 : 2'h2;
        end
      end
      ST_WAKE: begin
        if ((wake_src_r & irq_q) != 2'h0) begin
          state_nxt  = ST_HANDLER;
          wake_pulse = wake_src_r;
          pd_clear   = 1'b1;
        end
      end
      ST_HANDLER: begin
        if (i_return_from_interrupt) begin
          state_nxt    = ST_RUN;
          resume_pulse = 1'b1;
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r    <= ST_RUN;
      wake_src_r <= 2'h0;
      resume_r   <= 16'h0000;
    end else begin
      state_r    <= state_nxt;
      wake_src_r <= wake_src_nxt;
      resume_r   <= resume_nxt;
    end
  end

  // lock bit storage, survives warm reset
  logic [2:0] lock_r;
  logic [2:0] lock_nxt;
  prlc_protect_s prot_r;
  prlc_protect_s prot_nxt;
  prlc_level_e   level_r;
  prlc_level_e   level_nxt;
  logic          captured_r;
  logic          captured_nxt;
  logic          ea_latch_r;
  logic          ea_latch_nxt;

  always_comb begin
    lock_nxt = lock_r | i_lock_program;
    if (i_erase) begin
      lock_nxt = `PRLC_LOCK_NONE;
    end
  end

  always_ff @(posedge i_clock or negedge i_por_n) begin
    if (!i_por_n) begin
      lock_r <= `PRLC_LOCK_NONE;
    end else begin
      lock_r <= lock_nxt;
    end
  end

  // protection decoded once after reset release
  always_comb begin
    prot_nxt     = prot_r;
    level_nxt    = level_r;
    captured_nxt = 1'b1;
    ea_latch_nxt = ea_latch_r;
    if (!captured_r) begin
      ea_latch_nxt = ea_q;
      case (lock_r)
        `PRLC_LOCK_NONE: begin
          level_nxt = LVL_NONE;
          prot_nxt  = 5'b00000;
        end
        `PRLC_LOCK_ONE: begin
          level_nxt = LVL_ONE;
          prot_nxt  = 5'b11100;
        end
        `PRLC_LOCK_TWO: begin
          level_nxt = LVL_TWO;
          prot_nxt  = 5'b11110;
        end
        `PRLC_LOCK_THREE: begin
          level_nxt = LVL_THREE;
          prot_nxt  = 5'b11111;
        end
        default: begin
          level_nxt = LVL_UNDEF;
          prot_nxt  = 5'b11111;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      prot_r     <= 5'b11111;
      level_r    <= LVL_UNDEF;
      captured_r <= 1'b0;
      ea_latch_r <= 1'b0;
    end else begin
      prot_r     <= prot_nxt;
      level_r    <= level_nxt;
      captured_r <= captured_nxt;
      ea_latch_r <= ea_latch_nxt;
    end
  end

  // key array and code verify
  prlc_byte_t key_byte;
  prlc_byte_t vdata_r;
  prlc_byte_t vdata_nxt;
  logic       vvalid_r;
  logic       vvalid_nxt;
  logic       vrefused_r;
  logic       vrefused_nxt;

  prlc_key_array #(
    .DEPTH (KEY_DEPTH),
    .AW    (KAW)
  ) u_key (
    .i_clock (i_clock),
    .i_por_n (i_por_n),
    .i_write (i_key_write & ~prot_r.program_disable),
    .i_waddr (i_key_addr),
    .i_wdata (i_key_data),
    .i_erase (i_erase),
    .i_raddr (i_verify_addr[KAW-1:0]),
    .o_rdata (key_byte)
  );

  always_comb begin
    vdata_nxt    = vdata_r;
    vvalid_nxt   = 1'b0;
    vrefused_nxt = 1'b0;
    if (i_verify_req) begin
      if (prot_r.verify_disable) begin
        vrefused_nxt = 1'b1;
      end else begin
        vdata_nxt  = ~(i_code_byte ^ key_byte);
        vvalid_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      vdata_r    <= 8'h00;
      vvalid_r   <= 1'b0;
      vrefused_r <= 1'b0;
    end else begin
      vdata_r    <= vdata_nxt;
      vvalid_r   <= vvalid_nxt;
      vrefused_r <= vrefused_nxt;
    end
  end

  // emulation entry, judged from pins seen during reset
  logic emul_pend_r;
  logic emul_pend_nxt;
  logic emul_r;
  logic emul_nxt;

  always_comb begin
    emul_pend_nxt = emul_pend_r;
    emul_nxt      = emul_r;
    if (rst_q) begin
      emul_nxt = 1'b0;
      if (!rst_d_r) begin
        emul_pend_nxt = 1'b0;
      end
      if (!ale_q && program_store_enable_q) begin
        emul_pend_nxt = 1'b1;
      end
    end else if (rst_d_r) begin
      emul_nxt      = emul_pend_r | ~ale_q;
      emul_pend_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_por_n) begin
    if (!i_por_n) begin
      rst_d_r     <= 1'b0;
      emul_pend_r <= 1'b0;
      emul_r      <= 1'b0;
    end else begin
      rst_d_r     <= rst_q;
      emul_pend_r <= emul_pend_nxt;
      emul_r      <= emul_nxt;
    end
  end

  // registered outputs
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_osc_enable       <= 1'b1;
      o_powerdown_active <= 1'b0;
      o_wake_irq         <= 2'h0;
      o_resume_valid     <= 1'b0;
      o_sfr_reinit       <= 1'b1;
      o_external_access  <= 1'b0;
    end else begin
      o_osc_enable       <= (state_nxt != ST_DOWN) | emul_nxt;
      o_powerdown_active <= (state_nxt == ST_DOWN);
      o_wake_irq         <= wake_pulse;
      o_resume_valid     <= resume_pulse;
      o_sfr_reinit       <= rst_q;
      o_external_access  <= prot_nxt.ea_latched_mode ? ea_latch_nxt : ea_q;
    end
  end

  assign o_power_control_reg = power_control_reg_r;
  assign o_resume_addr       = resume_r;
  assign o_protect           = prot_r;
  assign o_level             = level_r;
  assign o_lock_bits         = lock_r;
  assign o_verify_data       = vdata_r;
  assign o_verify_valid      = vvalid_r;
  assign o_verify_refused    = vrefused_r;
  assign o_emul              = {emul_r, emul_r, emul_r};

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n || !i_por_n);

  a_osc_off_down: assert property (
    (o_powerdown_active && !emul_r) |-> !o_osc_enable)
    else $error("oscillator runs in power-down");
  a_wake_clears_pd: assert property (
    (o_wake_irq != 2'h0) |-> !power_control_reg_r[`PRLC_PD_BIT])
    else $error("power-down bit kept after wake");
  a_pof_sw_write: assert property (
    (i_power_control_reg_wr && !rst_q) |=> power_control_reg_r[`PRLC_POF_BIT] ==
      $past(i_power_control_reg_wdata[`PRLC_POF_BIT]))
    else $error("cold flag write lost");
  a_pof_kept: assert property (
    !i_power_control_reg_wr |=> $stable(power_control_reg_r[`PRLC_POF_BIT]))
    else $error("cold flag changed without write");
  a_verify_xnor: assert property (
    (i_verify_req && !prot_r.verify_disable) |=>
      o_verify_valid && o_verify_data == ~($past(i_code_byte) ^
      $past(key_byte)))
    else $error("verify byte not code xnor key");
  a_verify_off: assert property (
    (i_verify_req && level_r == LVL_TWO) |=>
      !o_verify_valid && o_verify_refused)
    else $error("verify not refused at level two");
  a_level_held: assert property (
    captured_r |=> $stable(level_r) && $stable(prot_r))
    else $error("protection level changed after capture");
  a_emul_held: assert property (
    (!rst_q && !rst_d_r) |=> $stable(emul_r))
    else $error("emulation mode changed without reset");
  a_resume_cause: assert property (
    o_resume_valid |-> $past(state_r) == ST_HANDLER &&
      $past(i_return_from_interrupt) && state_r == ST_RUN)
    else $error("resume without handler return");
  a_wake_sequence: assert property (
    (state_r == ST_DOWN && wake_low == 2'h0) |=> state_r == ST_DOWN)
    else $error("power-down left without level wake");
endmodule : prlc_top

// ---- tb/prlc_pin_model.sv ----
// pin-side model of the programmer, emulator or test cpu
module prlc_pin_model (
  input  wire logic i_clock,
  input  wire logic i_osc_enable,
  output logic      o_irq_zero,
  output logic      o_irq_one,
  output logic      o_ale,
  output logic      o_program_store_enable,
  output logic      o_ea
);
  timeunit 1ns;
  timeprecision 100ps;

  // released irq, strobe and enable lines sit at their pull-up level
  initial begin
    o_irq_zero = 1'b1;
    o_irq_one  = 1'b1;
    o_ale      = 1'b1;
    o_program_store_enable     = 1'b1;
    o_ea       = 1'b1;
  end

  // hold the pin low until the oscillator runs or 40 cycles pass, then for hold more cycles
  task automatic wake(input int idx, input int hold);
    int n;
    n = 0;
    @(negedge i_clock);
    if (idx == 0) o_irq_zero = 1'b0;
    else o_irq_one = 1'b0;
    while (!i_osc_enable && n < 40) begin
      @(negedge i_clock);
      n++;
    end
    repeat (hold) @(negedge i_clock);
    o_irq_zero = 1'b1;
    o_irq_one  = 1'b1;
  endtask : wake

  task automatic strap(input logic ale, input logic program_store_enable);
    o_ale  = ale;
    o_program_store_enable = program_store_enable;
  endtask : strap
endmodule : prlc_pin_model

// ---- tb/prlc_top_tb.sv ----
// self-checking bench for the power, lock and emulation block
module prlc_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import prlc_pkg::*;

  logic          i_clock = 1'b0;
  logic          i_reset_n, i_por_n, i_power_control_reg_wr, i_return_from_interrupt;
  logic          i_key_write, i_erase, i_verify_req;
  prlc_byte_t    i_power_control_reg_wdata, i_key_data, i_code_byte, power_control_reg, vdata;
  logic [1:0]    i_irq_enable, i_irq_level_mode, wake;
  logic [15:0]   i_next_pc, i_verify_addr, raddr;
  logic [2:0]    i_lock_program, lbits;
  logic [5:0]    i_key_addr;
  logic          irq0, irq1, ea, ale, program_store_enable, osc, pd, rv, reinit;
  logic          ext, vv, vref, vv_seen, vref_seen;
  prlc_protect_s prot;
  prlc_level_e   lvl;
  prlc_emul_s    emul;
  int            fail_count = 0;
  int            checked = 0;

  always #12.5 i_clock = ~i_clock;

  prlc_top dut_u (
    .i_clock, .i_reset_n, .i_por_n, .i_power_control_reg_wr, .i_power_control_reg_wdata,
    .i_ext_irq_zero(irq0), .i_ext_irq_one(irq1), .i_irq_enable,
    .i_irq_level_mode, .i_next_pc, .i_return_from_interrupt,
    .i_external_access_pin(ea), .i_ale(ale),
    .i_program_store_enable(program_store_enable), .i_lock_program, .i_key_write,
    .i_key_addr, .i_key_data, .i_erase, .i_verify_req, .i_verify_addr,
    .i_code_byte, .o_power_control_reg(power_control_reg), .o_osc_enable(osc),
    .o_powerdown_active(pd), .o_wake_irq(wake), .o_resume_valid(rv),
    .o_resume_addr(raddr), .o_sfr_reinit(reinit), .o_protect(prot),
    .o_level(lvl), .o_external_access(ext), .o_lock_bits(lbits),
    .o_verify_data(vdata), .o_verify_valid(vv),
    .o_verify_refused(vref), .o_emul(emul)
  );

  prlc_pin_model pin_u (
    .i_clock(i_clock), .i_osc_enable(osc), .o_irq_zero(irq0),
    .o_irq_one(irq1), .o_ale(ale), .o_program_store_enable(program_store_enable), .o_ea(ea)
  );

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic give_up(input string what);
    fail_count++;
    $display("[ERR] %s expected pulse seen none", what);
    tally_and_finish;
  endtask : give_up

  task automatic do_reset(input logic cold);
    @(negedge i_clock);
    i_reset_n = 1'b0;
    i_por_n   = ~cold;
    repeat (4) @(negedge i_clock);
    i_reset_n = 1'b1;
    i_por_n   = 1'b1;
    repeat (5) @(negedge i_clock);
  endtask : do_reset

  task automatic wr_power_control_reg(input prlc_byte_t d);
    i_power_control_reg_wr    = 1'b1;
    i_power_control_reg_wdata = d;
    @(negedge i_clock);
    i_power_control_reg_wr = 1'b0;
    repeat (3) @(negedge i_clock);
  endtask : wr_power_control_reg

  task automatic verify(input logic [15:0] a, input prlc_byte_t c);
    i_verify_req  = 1'b1;
    i_verify_addr = a;
    i_code_byte   = c;
    @(negedge i_clock);
    i_verify_req = 1'b0;
    vv_seen      = vv;
    vref_seen    = vref;
    @(negedge i_clock);
  endtask : verify

  task automatic prog(input logic kw, input logic [2:0] lb,
                      input logic er);
    i_key_write    = kw;
    i_lock_program = lb;
    i_erase        = er;
    @(negedge i_clock);
    i_key_write    = 1'b0;
    i_lock_program = 3'h0;
    i_erase        = 1'b0;
    @(negedge i_clock);
  endtask : prog

  task automatic t_flag;
    chk("power_control_reg cold", 16'h0010, 16'(power_control_reg));
    wr_power_control_reg(8'h00);
    chk("power_control_reg cleared", 16'h0000, 16'(power_control_reg));
    do_reset(1'b0);
    chk("power_control_reg warm", 16'h0000, 16'(power_control_reg));
    chk("reinit off", 16'h0000, 16'(reinit));
    do_reset(1'b1);
    chk("power_control_reg power-up", 16'h0010, 16'(power_control_reg));
    wr_power_control_reg(8'h00);
    wr_power_control_reg(8'h10);
    chk("power_control_reg set", 16'h0010, 16'(power_control_reg));
    $display("test flag done");
  endtask : t_flag

  task automatic t_wake;
    int n;
    i_irq_enable     = 2'b01;
    i_irq_level_mode = 2'b01;
    i_next_pc        = 16'h1234;
    wr_power_control_reg(8'h12);
    repeat (20) @(negedge i_clock);
    chk("down", 16'h0001, 16'(pd));
    chk("osc off", 16'h0000, 16'(osc));
    pin_u.wake(0, 8);
    chk("osc on", 16'h0001, 16'(osc));
    n = 0;
    while (wake === 2'b00 && n < 20) begin
      @(negedge i_clock);
      n++;
    end
    if (n == 20) give_up("wake");
    chk("wake source", 16'h0001, 16'(wake));
    chk("pd bit cleared", 16'h0010, 16'(power_control_reg));
    i_return_from_interrupt = 1'b1;
    @(negedge i_clock);
    i_return_from_interrupt = 1'b0;
    n = 0;
    while (rv !== 1'b1 && n < 4) begin
      @(negedge i_clock);
      n++;
    end
    if (n == 4) give_up("resume");
    chk("resume addr", 16'h1234, raddr);
    $display("test wake done");
  endtask : t_wake

  task automatic t_refuse;
    i_irq_enable     = 2'b10;
    i_irq_level_mode = 2'b00;
    wr_power_control_reg(8'h12);
    pin_u.wake(1, 4);
    repeat (4) @(negedge i_clock);
    chk("edge irq stays down", 16'h0001, 16'(pd));
    i_reset_n = 1'b0;
    repeat (4) @(negedge i_clock);
    chk("reinit", 16'h0001, 16'(reinit));
    chk("reset exits", 16'h0001, 16'(osc));
    chk("power_control_reg reinit", 16'h0010, 16'(power_control_reg));
    i_reset_n = 1'b1;
    repeat (5) @(negedge i_clock);
    $display("test refuse done");
  endtask : t_refuse

  task automatic t_verify;
    verify(16'h0000, 8'h5A);
    chk("valid", 16'h0001, 16'(vv_seen));
    chk("plain", 16'h005A, 16'(vdata));
    i_key_addr = 6'h01;
    i_key_data = 8'h0F;
    prog(1'b1, 3'h0, 1'b0);
    verify(16'h0041, 8'h5A);
    chk("valid keyed", 16'h0001, 16'(vv_seen));
    chk("xnor", 16'h00AA, 16'(vdata));
    $display("test verify done");
  endtask : t_verify

  task automatic t_locks;
    logic [2:0]  bits [3] = '{3'h1, 3'h3, 3'h7};
    prlc_level_e lv [3] = '{LVL_ONE, LVL_TWO, LVL_THREE};
    logic [4:0]  pr [3] = '{5'h1C, 5'h1E, 5'h1F};
    prlc_level_e held;
    held = LVL_NONE;
    chk("open", 16'h0000, 16'(prot));
    for (int i = 0; i < 3; i++) begin
      prog(1'b0, bits[i], 1'b0);
      chk("level held", 16'(held), 16'(lvl));
      do_reset(1'b0);
      held = lv[i];
      chk("level", 16'(held), 16'(lvl));
      chk("protect", 16'(pr[i]), 16'(prot));
      chk("lock bits", 16'(bits[i]), 16'(lbits));
      verify(16'h0002, 8'h5A);
      chk("refused", 16'(i > 0), 16'(vref_seen));
    end
    do_reset(1'b0);
    prog(1'b1, 3'h0, 1'b0);
    prog(1'b0, 3'h0, 1'b1);
    chk("erased bits", 16'h0000, 16'(lbits));
    do_reset(1'b0);
    chk("unlocked", 16'h0000, 16'(prot));
    verify(16'h0041, 8'h5A);
    chk("key erased", 16'h005A, 16'(vdata));
    prog(1'b0, 3'h1, 1'b0);
    do_reset(1'b0);
    prog(1'b1, 3'h0, 1'b0);
    verify(16'h0001, 8'h3C);
    chk("no key prog", 16'h003C, 16'(vdata));
    pin_u.o_ea = 1'b0;
    repeat (4) @(negedge i_clock);
    chk("ea latched", 16'h0001, 16'(ext));
    pin_u.o_ea = 1'b1;
    prog(1'b0, 3'h0, 1'b1);
    prog(1'b0, 3'h2, 1'b0);
    do_reset(1'b0);
    chk("undefined", 16'(LVL_UNDEF), 16'(lvl));
    chk("undefined prot", 16'h001F, 16'(prot));
    prog(1'b0, 3'h0, 1'b1);
    do_reset(1'b0);
    $display("test locks done");
  endtask : t_locks

  task automatic t_emul;
    pin_u.strap(1'b0, 1'b1);
    do_reset(1'b0);
    pin_u.strap(1'b1, 1'b1);
    chk("emul on", 16'h0007, 16'(emul));
    wr_power_control_reg(8'h12);
    chk("emul down", 16'h0001, 16'(pd));
    chk("osc runs", 16'h0001, 16'(osc));
    repeat (10) @(negedge i_clock);
    chk("emul held", 16'h0007, 16'(emul));
    do_reset(1'b0);
    chk("emul off", 16'h0000, 16'(emul));
    pin_u.strap(1'b0, 1'b0);
    do_reset(1'b0);
    chk("emul at release", 16'h0007, 16'(emul));
    pin_u.strap(1'b1, 1'b1);
    do_reset(1'b0);
    chk("emul off again", 16'h0000, 16'(emul));
    $display("test emul done");
  endtask : t_emul

  initial begin
    i_reset_n = 1'b0;
    i_por_n = 1'b0;
    {i_power_control_reg_wr, i_return_from_interrupt, i_key_write} = 3'h0;
    {i_erase, i_verify_req, i_lock_program} = 5'h00;
    {i_power_control_reg_wdata, i_key_data, i_code_byte} = 24'h000000;
    {i_irq_enable, i_irq_level_mode, i_key_addr} = 10'h000;
    {i_next_pc, i_verify_addr} = 32'h00000000;
    repeat (3) @(negedge i_clock);
    i_reset_n = 1'b1;
    i_por_n = 1'b1;
    repeat (5) @(negedge i_clock);
    t_flag();
    t_wake();
    t_refuse();
    t_verify();
    t_locks();
    t_emul();
    tally_and_finish();
  end
endmodule : prlc_top_tb
